/* bench/sram_ctrl_model.sv */
/*
 Behavioural memory controller that drives the command pins of the burst
 memory port. Assumes it is called at the falling clock edge, so every pin
 is stable around the next rising edge.
*/
`timescale 1ns/1ns
module sram_ctrl_model (
   input  wire logic   clock_i,
   output logic [5:0]  addr_o,
   output logic [35:0] data_o,
   output logic        sel1_n_o,
   output logic        sel2_o,
   output logic        sel3_n_o,
   output logic        pstb_n_o,
   output logic        cstb_n_o,
   output logic        step_n_o,
   output logic        all_n_o,
   output logic        part_n_o,
   output logic [3:0]  lane_n_o
);
   // Address and data pins that carry no meaning get the inverse of their last value.
   task put(input logic [5:0] a, input logic cs_n, ps_n, st_n, al_n, pa_n,
            input logic [3:0] ln, input logic [35:0] d,
            input logic c1_n, c2);
      addr_o = a;
      cstb_n_o = cs_n;
      pstb_n_o = ps_n;
      step_n_o = st_n;
      all_n_o = al_n;
      part_n_o = pa_n;
      lane_n_o = ln;
      data_o = (al_n & pa_n) ? ~data_o : d;
      sel1_n_o = c1_n;
      sel2_o = c2;
      sel3_n_o = 1'b0;
   endtask
   task idle;
      put(~addr_o, 1, 1, 1, 1, 1, 4'hf, 0, 0, 1);
   endtask
   task load(input logic [5:0] a, input logic al_n, input logic [35:0] d);
      put(a, 0, 1, 1, al_n, 1, 4'hf, d, 0, 1);
   endtask
   task cont(input logic [3:0] ln, input logic [35:0] d);
      put(~addr_o, 1, 1, 0, 1, &ln, ln, d, 0, 1);
   endtask
   task pread(input logic [5:0] a, input logic c1_n);
      put(a, 1, 0, 1, 1, 1, 4'hf, 0, c1_n, 1);
   endtask
   task desel(input logic two);
      put(~addr_o, 0, 1, 1, 1, 1, 4'hf, 0, ~two, ~two);
   endtask
   initial begin
      data_o = 36'h0;
      addr_o = 6'h0;
      idle;
   end
endmodule

/* bench/sync_burst_sram_port_bench.sv */
/*
 Self-checking bench of the burst memory port with a small array.
 Assumes the controller model drives the command pins and the bench
 drives the mode, output enable and sleep pins.
*/
`timescale 1ns/1ns
module sync_burst_sram_port_bench;
   import sync_sram_pkg::*;
   logic        clock_i = 1'b0;
   logic        srst_i  = 1'b1;
   logic [5:0]  addr;
   logic [35:0] wdata;
   logic [35:0] dq_o;
   logic        dq_oe_o;
   logic        sel1_n, sel2, sel3_n, pstb_n, cstb_n, step_n, all_n, part_n;
   logic [3:0]  lane_n;
   logic        oe_n    = 1'b0;
   logic        sleep   = 1'b0;
   logic        lin_n   = 1'b0;
   logic        byp_n   = 1'b1;
   logic        one_cyc = 1'b0;
   logic [35:0] exp_mem [0:63];
   int          fails   = 0;
   int          n_tests = 0;

   always #5 clock_i = ~clock_i;

   sram_ctrl_model ctl_u (.clock_i(clock_i), .addr_o(addr), .data_o(wdata),
      .sel1_n_o(sel1_n), .sel2_o(sel2), .sel3_n_o(sel3_n),
      .pstb_n_o(pstb_n), .cstb_n_o(cstb_n), .step_n_o(step_n),
      .all_n_o(all_n), .part_n_o(part_n), .lane_n_o(lane_n));

   sync_burst_sram_port #(.ADDR_W(6), .DATA_W(36), .MODE_PINS_DRIVEN(1'b1))
   dut_u (.clock_i(clock_i), .srst_i(srst_i), .address_i(addr),
      .dq_i(wdata), .dq_o(dq_o), .dq_oe_o(dq_oe_o),
      .chip_select_one_n_i(sel1_n), .chip_select_two_i(sel2),
      .chip_select_three_n_i(sel3_n), .proc_address_strobe_n_i(pstb_n),
      .ctrl_address_strobe_n_i(cstb_n), .burst_step_enable_n_i(step_n),
      .all_lanes_write_n_i(all_n), .partial_write_enable_n_i(part_n),
      .lane_write_strobe_n_i(lane_n), .output_enable_n_i(oe_n),
      .sleep_request_i(sleep), .linear_order_select_n_i(lin_n),
      .output_register_bypass_select_n_i(byp_n),
      .deselect_latency_select_i(one_cyc));

   task step;
      @(posedge clock_i);
      @(negedge clock_i);
   endtask
   task chk(input logic [35:0] got, input logic [35:0] want);
      n_tests++;
      if (got !== want) begin
         fails++;
         $display("wrong value at %0t: got %h want %h", $time, got, want);
      end
   endtask
   task give_verdict;
      $display("comparisons %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // A fresh address every cycle, then a partial write that wraps to 0.
   task t_write;
      for (int i = 0; i < 4; i++) begin
         ctl_u.load(i[5:0], 1'b0, 36'h5a5a5a5a0 + 36'(i));
         step;
         exp_mem[i] = 36'h5a5a5a5a0 + 36'(i);
      end
      ctl_u.cont(4'b1110, 36'hfffffffff);
      step;
      exp_mem[0][8:0] = 9'h1ff;
      ctl_u.idle;
      step;
   endtask
   task t_burst(input logic lin, input logic [1:0] base);
      logic [1:0] a;
      // End the earlier burst so the order change meets no access.
      ctl_u.desel(1'b0);
      step;
      lin_n = ~lin;
      for (int k = 0; k < 6; k++) begin
         if (k == 0)
            ctl_u.load({4'h0, base}, 1'b1, 36'h0);
         else if (k < 5)
            ctl_u.cont(4'hf, 36'h0);
         else
            ctl_u.idle;
         step;
         if (k > 0) begin
            a = lin ? base + 2'(k - 1) : base ^ 2'(k - 1);
            chk(dq_o, exp_mem[a]);
            chk(36'(dq_oe_o), 36'h1);
         end
         if (k == 2) begin
            oe_n = 1'b1;
            #1 chk(36'(dq_oe_o), 36'h0);
            oe_n = 1'b0;
            sleep = 1'b1;
            #1 chk(36'(dq_oe_o), 36'h0);
            sleep = 1'b0;
         end
      end
   endtask
   task t_flow;
      ctl_u.idle;
      step;
      byp_n = 1'b0;
      ctl_u.pread(6'h01, 1'b0);
      step;
      chk(dq_o, exp_mem[1]);
      chk(36'(dq_oe_o), 36'h1);
      ctl_u.pread(6'h02, 1'b1);
      step;
      // The ignored strobe leaves the burst reading the same word.
      chk(36'(dq_oe_o), 36'h1);
      chk(dq_o, exp_mem[1]);
      ctl_u.idle;
      step;
      byp_n = 1'b1;
   endtask
   // Dual-cycle deselect through the first select, single through the second.
   task t_desel;
      for (int s = 0; s < 2; s++) begin
         one_cyc = s[0];
         ctl_u.load(6'h02, 1'b1, 36'h0);
         step;
         ctl_u.desel(s[0]);
         step;
         chk(36'(dq_oe_o), 36'(s == 0));
         ctl_u.idle;
         step;
         chk(36'(dq_oe_o), 36'h0);
      end
      one_cyc = 1'b0;
   endtask

   initial begin
      repeat (16) @(posedge clock_i);
      @(negedge clock_i);
      srst_i = 1'b0;
      t_write;
      t_burst(1'b1, 2'h1);
      t_burst(1'b0, 2'h1);
      t_flow;
      t_desel;
      give_verdict;
   end
   // The tests need well under a thousand cycles.
   initial begin
      #10000;
      fails++;
      give_verdict;
   end
endmodule

/* hdl/burst_counter.sv */
/*
 Two-bit burst address counter with linear or interleaved order.
 Assumes load and step are never asked for in the same cycle by the
 caller; load wins if they are.
*/
`timescale 1ns/1ns
module burst_counter (
   input  wire logic                  clock_i,
   input  wire logic                  srst_i,
   input  wire logic                  load_i,
   input  wire sync_sram_pkg::burst_t base_i,
   input  wire logic                  step_i,
   input  wire logic                  linear_i,
   output sync_sram_pkg::burst_t      next_addr_o,
   output sync_sram_pkg::burst_t      addr_o
);
   import sync_sram_pkg::*;

   typedef struct packed {
      burst_t base;
      burst_t count;
   } ctr_s;

   ctr_s st;
   ctr_s next_st;

   // Order is applied on the way out, so a mode change shows at once.
   function automatic burst_t order(input ctr_s s, input logic lin);
      order = lin ? burst_t'(s.base + s.count) : (s.base ^ s.count);
   endfunction

   always_comb begin
      next_st = st;
      if (load_i) begin
         next_st.base  = base_i;
         next_st.count = BURST_ZERO;
      end else if (step_i) begin
         next_st.count = burst_t'(st.count + BURST_ONE);
      end
      next_addr_o = order(next_st, linear_i);
      addr_o      = order(st, linear_i);
   end

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

endmodule

/* hdl/sync_burst_sram_port.sv */
/*
 Synchronous burst static memory seen from its pins: address strobes,
 burst counter, byte and all-lane writes, flow-through or pipelined
 reads and single- or, when pipelined, dual-cycle deselect.
 Assumes every synchronous input is stable around the rising clock edge
 and that the data pin level is resolved outside from dq_oe_o.
*/
`timescale 1ns/1ns
module sync_burst_sram_port #(
   parameter int ADDR_W           = sync_sram_pkg::DEF_ADDR_W,
   parameter int DATA_W           = sync_sram_pkg::DEF_DATA_W,
   parameter bit MODE_PINS_DRIVEN = 1'b1,
   localparam int LANES           = DATA_W / sync_sram_pkg::BYTE_W
) (
   input  wire logic              clock_i,
   input  wire logic              srst_i,
   input  wire logic [ADDR_W-1:0] address_i,
   input  wire logic [DATA_W-1:0] dq_i,
   output logic      [DATA_W-1:0] dq_o,
   output logic                   dq_oe_o,
   input  wire logic              chip_select_one_n_i,
   input  wire logic              chip_select_two_i,
   input  wire logic              chip_select_three_n_i,
   input  wire logic              proc_address_strobe_n_i,
   input  wire logic              ctrl_address_strobe_n_i,
   input  wire logic              burst_step_enable_n_i,
   input  wire logic              all_lanes_write_n_i,
   input  wire logic              partial_write_enable_n_i,
   input  wire logic [LANES-1:0]  lane_write_strobe_n_i,
   input  wire logic              output_enable_n_i,
   input  wire logic              sleep_request_i,
   input  wire logic              linear_order_select_n_i,
   input  wire logic              output_register_bypass_select_n_i,
   input  wire logic              deselect_latency_select_i
);
   import sync_sram_pkg::*;

   localparam int HI_W = ADDR_W - CTR_W;

   // Smaller address widths above the counter width are accepted so a simulation can use a
   // small array; wider ones than the organisation allows are refused.
   if (!((DATA_W == DATA_W_X18 && ADDR_W <= ADDR_W_X18) ||
         (DATA_W == DATA_W_X36 && ADDR_W <= ADDR_W_X36) ||
         (DATA_W == DATA_W_X72 && ADDR_W <= ADDR_W_X72)) ||
       ADDR_W <= CTR_W) begin : g_bad_org
      $error("unsupported organisation");
   end
   if (!MODE_PINS_DRIVEN && DATA_W == DATA_W_X72) begin : g_bad_float
      $error("wide organisation has no floating mode defaults");
   end

   typedef struct packed {
      logic [HI_W-1:0]   addr_hi;
      logic              act;
      logic              s1_rd;
      logic              s1_ds;
      logic              drive;
      logic [DATA_W-1:0] dout;
   } state_s;

   state_s            st;
   state_s            next_st;
   mode_s             mode;
   cmd_e              cmd;
   logic [DATA_W-1:0] mem [0:(1 << ADDR_W) - 1];
   logic [DATA_W-1:0] wmask;
   logic [LANES-1:0]  lane_we;
   logic [HI_W-1:0]   next_hi;
   logic [ADDR_W-1:0] cyc_addr;
   logic [ADDR_W-1:0] rd_addr;
   burst_t            cnt_next;
   burst_t            cnt_q;
   logic              selected;
   logic              start_p;
   logic              start_c;
   logic              start;
   logic              load;
   logic              cont;
   logic              step;
   logic              wr_any;

   always_comb begin
      if (MODE_PINS_DRIVEN) begin
         mode.pipelined    = output_register_bypass_select_n_i;
         mode.single_cycle = deselect_latency_select_i;
         mode.linear       = !linear_order_select_n_i;
      end else begin
         mode.pipelined    = FLOAT_PIPELINED;
         mode.single_cycle = FLOAT_SINGLE;
         mode.linear       = FLOAT_LINEAR;
      end
   end

   // The processor strobe is ignored while the first select is high,
   // so a shared processor bus can strobe without waking this part.
   always_comb begin
      selected = !chip_select_one_n_i && chip_select_two_i &&
                 !chip_select_three_n_i;
      start_p  = !proc_address_strobe_n_i && !chip_select_one_n_i &&
                 !sleep_request_i;
      start_c  = !ctrl_address_strobe_n_i && !sleep_request_i;
      start    = start_p || start_c;
      load     = start && selected;
      cont     = st.act && !start && !sleep_request_i;
      step     = cont && !burst_step_enable_n_i;
      if (!all_lanes_write_n_i) begin
         lane_we = '1;
      end else if (!partial_write_enable_n_i) begin
         lane_we = ~lane_write_strobe_n_i;
      end else begin
         lane_we = '0;
      end
      wr_any = |lane_we;
      if (start && !selected) begin
         cmd = CMD_DESEL;
      end else if (start_p) begin
         cmd = CMD_READ;
      end else if (start || cont) begin
         cmd = wr_any ? CMD_WRITE : CMD_READ;
      end else begin
         cmd = CMD_IDLE;
      end
   end

   for (genvar g = 0; g < LANES; g++) begin : g_lane
      assign wmask[g*BYTE_W +: BYTE_W] = {BYTE_W{lane_we[g]}};
   end

   burst_counter u_counter (
      .clock_i     (clock_i),
      .srst_i      (srst_i),
      .load_i      (load),
      .base_i      (address_i[CTR_W-1:0]),
      .step_i      (step),
      .linear_i    (mode.linear),
      .next_addr_o (cnt_next),
      .addr_o      (cnt_q)
   );

   always_comb begin
      next_hi  = load ? address_i[ADDR_W-1:CTR_W] : st.addr_hi;
      cyc_addr = {next_hi, cnt_next};
      rd_addr  = {st.addr_hi, cnt_q};
   end

   // Drive follows the read through one or two stages; a single-cycle
   // deselect cuts it in the same cycle the deselect is captured.
   always_comb begin
      next_st         = st;
      next_st.addr_hi = next_hi;
      if (cmd == CMD_DESEL) begin
         next_st.act = 1'b0;
      end else if (load) begin
         next_st.act = 1'b1;
      end
      next_st.s1_rd = (cmd == CMD_READ);
      next_st.s1_ds = (cmd == CMD_DESEL);
      if (mode.pipelined) begin
         next_st.drive = st.s1_rd &&
                         !(mode.single_cycle && next_st.s1_ds);
      end else begin
         next_st.drive = next_st.s1_rd;
      end
      if (st.s1_rd) begin
         next_st.dout = mem[rd_addr];
      end
   end

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // The array write completes at the capture edge; no strobe is needed.
   always_ff @(posedge clock_i) begin
      if (!srst_i && cmd == CMD_WRITE) begin
         mem[cyc_addr] <= (mem[cyc_addr] & ~wmask) |
                          (dq_i & wmask);
      end
   end

   // Enable and sleep gate dq_oe_o without a clock and flow-through reads
   always_comb begin
      dq_o    = mode.pipelined ? st.dout : mem[rd_addr];
      dq_oe_o = st.drive && !output_enable_n_i &&
                !sleep_request_i;
   end

   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (srst_i);

   oe_gate_a : assert property (
      output_enable_n_i |-> !dq_oe_o)
      else $error("data pins driven with output enable off");

   sleep_off_a : assert property (
      sleep_request_i |-> !dq_oe_o && !load && cmd == CMD_IDLE)
      else $error("activity while sleep is requested");

   flow_read_a : assert property (
      cmd == CMD_READ && !mode.pipelined |=> st.drive &&
      dq_o == mem[$past(cyc_addr)])
      else $error("flow-through read not shown after capture");

   pipe_read_a : assert property (
      cmd == CMD_READ && mode.pipelined ##1
      !(cmd == CMD_DESEL && mode.single_cycle) |=> st.drive)
      else $error("pipelined read not shown one stage later");

   single_desel_a : assert property (
      cmd == CMD_DESEL && mode.pipelined && mode.single_cycle
      |=> !st.drive)
      else $error("single-cycle deselect did not cut outputs");

   dual_desel_a : assert property (
      cmd == CMD_DESEL && mode.pipelined && !mode.single_cycle &&
      st.s1_rd |=> st.drive ##1 !st.drive)
      else $error("dual-cycle deselect timing wrong");

   addr_load_a : assert property (
      load |=> cnt_q == $past(address_i[CTR_W-1:0]) &&
      st.addr_hi == $past(address_i[ADDR_W-1:CTR_W]))
      else $error("strobe did not load the address");

   burst_hold_a : assert property (
      cont && burst_step_enable_n_i |=> cnt_q == $past(cnt_q))
      else $error("burst address moved without advance");

   linear_step_a : assert property (
      step && mode.linear |-> cnt_next == burst_t'(cnt_q + BURST_ONE))
      else $error("linear burst step wrong");

   burst_wrap_a : assert property (
      step [*4] |-> cnt_next == $past(cnt_q, 3))
      else $error("burst did not wrap after four steps");

   all_lanes_a : assert property (
      cmd == CMD_WRITE && !all_lanes_write_n_i
      |=> mem[$past(cyc_addr)] == $past(dq_i))
      else $error("all-lanes write did not store every lane");

   partial_lane_a : assert property (
      cmd == CMD_WRITE && all_lanes_write_n_i |=>
      mem[$past(cyc_addr)] == (($past(dq_i) & $past(wmask)) |
                               ($past(mem[cyc_addr]) & ~$past(wmask))))
      else $error("partial write touched unselected lanes");

   flow_off_a : assert property (
      cmd != CMD_READ && !mode.pipelined
      |=> !st.drive)
      else $error("flow-through outputs stayed on without a read");

   proc_ignore_a : assert property (
      !proc_address_strobe_n_i && chip_select_one_n_i &&
      ctrl_address_strobe_n_i |-> !load && cmd != CMD_DESEL)
      else $error("processor strobe acted with first select high");

   sleep_hold_a : assert property (
      sleep_request_i
      |=> st.act == $past(st.act))
      else $error("burst state changed during sleep");

   oe_follow_a : assert property (
      st.drive && !output_enable_n_i && !sleep_request_i
      |-> dq_oe_o)
      else $error("data pins not driven with output enable on");

   pipe_data_a : assert property (
      st.s1_rd && mode.pipelined
      |=> dq_o == $past(mem[rd_addr]))
      else $error("pipelined read data not registered");

   desel_end_a : assert property (
      cmd == CMD_DESEL
      |=> !st.act && !st.s1_rd)
      else $error("deselect did not end the burst");

endmodule

/* hdl/sync_sram_pkg.sv */
/*
 Shared constants and types of the synchronous burst memory port: lane
 and counter widths, organisation limits, mode defaults and commands.
 Assumes it is compiled before every module that imports it.
*/
package sync_sram_pkg;

   // One byte lane carries eight data bits and one parity bit.
   localparam int BYTE_W     = 9;
   localparam int CTR_W      = 2;
   localparam int DEF_ADDR_W = 21;
   localparam int DEF_DATA_W = 36;

   localparam int DATA_W_X18 = 18;
   localparam int DATA_W_X36 = 36;
   localparam int DATA_W_X72 = 72;
   localparam int ADDR_W_X18 = 22;
   localparam int ADDR_W_X36 = 21;
   localparam int ADDR_W_X72 = 20;

   // Levels that the internal resistors give to unconnected mode inputs.
   localparam logic FLOAT_PIPELINED = 1'b1;
   localparam logic FLOAT_SINGLE    = 1'b1;
   localparam logic FLOAT_LINEAR    = 1'b0;

   typedef logic [CTR_W-1:0] burst_t;

   localparam burst_t BURST_ZERO = 2'h0;
   localparam burst_t BURST_ONE  = 2'h1;

   typedef enum logic [1:0] {
      CMD_IDLE  = 2'b00,
      CMD_READ  = 2'b01,
      CMD_WRITE = 2'b11,
      CMD_DESEL = 2'b10
   } cmd_e;

   typedef struct packed {
      logic pipelined;
      logic single_cycle;
      logic linear;
   } mode_s;

endpackage
